/* dv/dsrb_host.sv */
// Host model: issues reads and owns the diagnostic flag sources.
// Assumes the bank takes a read at a rising edge with valid high.
`timescale 1ns/10ps
`default_nettype none
module dsrb_host (
  // Clock
  input wire logic i_clk_sys,
  // Bank side
  output var dsrb_pkg::dsrb_rd_req_t o_rd,
  output var dsrb_pkg::dsrb_diag_t o_diag
);
  // ====
  // Reset-seen flag starts set, as after power-up
  initial begin
    o_rd = '0;
    o_diag = '0;
    o_diag.dig_flags = 16'h8000;
  end
  // Reads double as periodic count polls
  task automatic rd(input logic [4:0] a);
    @(negedge i_clk_sys);
    o_rd = {1'b1, a};
  endtask
  task automatic idle;
    @(negedge i_clk_sys);
    o_rd.valid = 1'b0;
  endtask
  // Sparse patterns so summaries also read low
  task automatic put(input logic [31:0] r, s);
    o_diag = {r[15:0] & {{13{s[0]}}, 3'h7}, s[14:1] & {14{s[15]}},
      s[18:16], s[23:19], r[27:16]};
  endtask
  // A flag clears only where a one is written
  task automatic clear(input logic [15:0] m);
    o_diag.dig_flags = o_diag.dig_flags & ~m;
  endtask
endmodule
`default_nettype wire

/* dv/dsrb_readback_asserts.sv */
// Checker for the readback bank, bound to its top.
// Assumes one clock and reset active low.
`timescale 1ns/10ps
`default_nettype none
module dsrb_readback_asserts #(
  parameter logic [2:0] POWER_DIE_REV = 3'h1,
  parameter logic [7:0] CORE_DIE_REV = 8'h01
) (
  // Watched ports
  input wire logic i_clk_sys, i_resetn, i_fault_pin,
  input wire logic i_serial_error_quiet_enable, i_osc_monitor_enable,
  input wire dsrb_pkg::dsrb_diag_t i_diag,
  input wire dsrb_pkg::dsrb_rd_req_t i_rd,
  input wire logic o_rd_valid, o_rd_err, o_digital_diag_summary,
  input wire logic o_analog_diag_summary,
  input wire logic [21:0] o_rd_data
);
  // ====
  // Address of the read being answered
  logic [4:0] a_q;
  logic [15:0] keep;
  always_ff @(posedge i_clk_sys) a_q <= i_rd.addr;
  assign keep = {~i_diag.slew_busy_pos, 12'hfff,
    {3{~i_serial_error_quiet_enable}}};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  chk_read_answer: assert property (i_rd.valid |=> o_rd_valid)
    else $error("read not answered");
  chk_refused_read: assert property (o_rd_valid |-> (o_rd_err ==
    !(a_q inside {[5'h16:5'h18]})) && (!o_rd_err || o_rd_data == 22'h0))
    else $error("refusal wrong");
  chk_fault_bit: assert property (o_rd_valid && !o_rd_err &&
    $past(i_fault_pin, 2) == $past(i_fault_pin) |->
    o_rd_data[21] == !$past(i_fault_pin)) else $error("fault bit");
  chk_id_word: assert property (o_rd_valid && a_q == 5'h17 |->
    o_rd_data[20:0] == {5'h17, 5'h0, POWER_DIE_REV, CORE_DIE_REV})
    else $error("id word");
  chk_count_addr: assert property (o_rd_valid && a_q == 5'h18 |->
    o_rd_data[20:16] == 5'h18) else $error("count address");
  chk_ana_sum: assert property ($past(i_resetn) |->
    o_analog_diag_summary == |$past(i_diag.ana_flags)) else $error("ana");
  chk_dig_sum: assert property ($past(i_resetn) |->
    o_digital_diag_summary == |$past(i_diag.dig_flags & keep))
    else $error("dig");
  chk_dig_reset: assert property ($rose(i_resetn) |->
    o_digital_diag_summary) else $error("dig after reset");
  cover property (o_rd_valid && a_q == 5'h16);
  cover property (o_rd_valid && o_rd_err);
  cover property (o_digital_diag_summary ##1 !o_digital_diag_summary);
endmodule
bind dsrb_readback dsrb_readback_asserts #(.POWER_DIE_REV(POWER_DIE_REV),
  .CORE_DIE_REV(CORE_DIE_REV)) u_chk (.i_clk_sys(i_clk_sys),
  .i_resetn(i_resetn), .i_fault_pin(i_fault_pin), .i_diag(i_diag),
  .i_serial_error_quiet_enable(i_serial_error_quiet_enable),
  .i_osc_monitor_enable(i_osc_monitor_enable), .i_rd(i_rd),
  .o_rd_valid(o_rd_valid), .o_rd_err(o_rd_err), .o_rd_data(o_rd_data),
  .o_digital_diag_summary(o_digital_diag_summary),
  .o_analog_diag_summary(o_analog_diag_summary));
`default_nettype wire

/* dv/test_diagnostic_status_readback.sv */
// Bench for the readback bank: host model reads, monitor compares.
// Assumes a divide of 8 so tick counts stay short.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
 miscompares++; $display("wrong value %s exp %h got %h", n, e, a); end end
module test_diagnostic_status_readback;
  logic clk = 0, rst_n = 0, flt = 0, qt = 0, en = 1, vld, err, ds, as;
  logic [21:0] dat, last, qm[$];
  logic [22:0] qe[$];
  logic [15:0] c0, d;
  logic [22:0] ex;
  int miscompares = 0, tests_run = 0;
  dsrb_pkg::dsrb_rd_req_t rd;
  dsrb_pkg::dsrb_diag_t dg;
  dsrb_host host (.i_clk_sys(clk), .o_rd(rd), .o_diag(dg));
  dsrb_readback #(.DIVIDE(8)) uut (.i_clk_sys(clk), .i_resetn(rst_n),
    .i_fault_pin(flt), .i_serial_error_quiet_enable(qt),
    .i_osc_monitor_enable(en), .i_diag(dg), .i_rd(rd), .o_rd_valid(vld),
    .o_rd_data(dat), .o_rd_err(err), .o_digital_diag_summary(ds),
    .o_analog_diag_summary(as));
  initial forever #5 clk = ~clk;
  function automatic logic [22:0] st();
    logic [15:0] k;
    k = {~dg.slew_busy_pos, 12'hfff, {3{~qt}}};
    return {1'b0, ~flt, |(dg.dig_flags & k), |dg.ana_flags, dg.watchdog,
      dg.conv_busy, dg.conv_ch, dg.conv_data};
  endfunction
  task automatic rx(input logic [4:0] a, input logic [22:0] e,
    input logic [21:0] m = '1);
    qe.push_back(e);
    qm.push_back(m);
    host.rd(a);
  endtask
  // Two count reads n+3 cycles apart; d is the advance
  task automatic span(input int n, output logic [15:0] dd);
    repeat (2) @(negedge clk);
    for (int j = 0; j < 2; j++) begin
      rx(5'h18, {1'h0, ~flt, 5'h18, 16'h0}, 22'h3f0000);
      host.idle;
      @(negedge clk);
      if (j == 0) begin
        c0 = last[15:0];
        repeat (n) @(negedge clk);
      end
    end
    dd = last[15:0] - c0;
  endtask
  // Sampled mid-cycle, well away from the edge that launches the answer
  always @(negedge clk) if (vld === 1'b1) begin : mon
    logic [22:0] e;
    logic [21:0] m;
    e = qe.pop_front();
    m = qm.pop_front();
    last = dat;
    `CHK("read word", e, {err, dat & m})
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'h4667));
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1;
    repeat (2) @(negedge clk);
    rx(5'h16, st());
    host.idle;
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      flt = 1'($urandom);
      qt = 1'($urandom);
      host.put($urandom, $urandom);
      repeat (3) @(negedge clk);
      ex = st();
      `CHK("digital summary", ex[20], ds)
      `CHK("analog summary", ex[19], as)
      rx(5'h16, ex);
      rx(5'h17, {1'h0, ~flt, 5'h17, 5'h0, 3'h1, 8'h01});
      rx(5'(i), 23'h400000);
      host.idle;
    end
    @(negedge clk);
    host.clear(16'hffff);
    repeat (3) @(negedge clk);
    `CHK("cleared summary", 1'h0, ds)
    rx(5'h16, st());
    host.idle;
    $display("test status done");
    span(80, d);
    `CHK("tick advance", 1'b1, d inside {[9:11]})
    en = 0;
    span(40, d);
    `CHK("held count", 16'h0, d)
    $display("test ticks done");
    give_verdict;
  end
endmodule
`default_nettype wire

/* hdl/dsrb_pkg.sv */
// Package for the diagnostic status readback bank: offsets, fields, resets.
// Assumes a 100 MHz system clock standing in for the internal oscillator.
package dsrb_pkg;

  // ==========================================================================
  // Register offsets (register address field values)
  localparam logic [4:0] OFS_SUMMARY_STATUS = 5'h16;
  localparam logic [4:0] OFS_DIE_REVISION = 5'h17;
  localparam logic [4:0] OFS_OSC_TICK_COUNT = 5'h18;

  // ==========================================================================
  // Common readback word layout
  localparam int REG_W = 22;
  localparam int FAULT_BIT = 21;
  localparam int ADDR_LSB = 16;
  localparam int ADDR_MSB = 20;

  // ==========================================================================
  // Summary status fields
  localparam int DIG_SUM_BIT = 20;
  localparam int ANA_SUM_BIT = 19;
  localparam int WDOG_BIT = 18;
  localparam int CONV_BUSY_BIT = 17;
  localparam int CH_LSB = 12;
  localparam int CH_MSB = 16;
  localparam int DATA_MSB = 11;

  // ==========================================================================
  // Digital and analog flag register layout
  localparam int DIG_FLAGS_W = 16;
  localparam int ANA_FLAGS_W = 14;
  localparam int SLEW_BUSY_BIT = 15;
  localparam int QUIET_LSB = 3;
  localparam int RESET_SEEN_BIT = 15;
  localparam logic [15:0] SLEW_MASK = 16'h0000;

  // ==========================================================================
  // Die revision fields
  localparam int PWR_REV_LSB = 8;
  localparam int PWR_REV_MSB = 10;
  localparam int CORE_REV_MSB = 7;

  // ==========================================================================
  // Reset values
  localparam logic [21:0] RST_SUMMARY_STATUS = 22'h100000;
  localparam logic [21:0] RST_OSC_TICK_COUNT = 22'h180000;
  localparam logic [15:0] RST_TICK_COUNT = 16'h0000;
  localparam logic RST_OSC_MON_EN = 1'b1;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_HZ = 1000;
  localparam int OSC_DIVIDE = 10_000;

  // Read request carried into the bank
  typedef struct packed {
    logic valid;
    logic [4:0] addr;
  } dsrb_rd_req_t;

  // Diagnostic inputs gathered from neighbouring blocks
  typedef struct packed {
    logic [15:0] dig_flags;
    logic [13:0] ana_flags;
    logic slew_busy_pos;
    logic watchdog;
    logic conv_busy;
    logic [4:0] conv_ch;
    logic [11:0] conv_data;
  } dsrb_diag_t;

endpackage

/* hdl/dsrb_readback.sv */
// Readback bank: summary status, die revision and oscillator tick count.
// Assumes flag registers, watchdog and converter live in neighbouring
// blocks and a serial front end issues register reads by address.
// Behaviour
// (RULE1) Bit 21 of each readback word is the inverted fault pin level; unmapped reads here return all zeros.
// (RULE2) Bit 20 ORs digital flags 15..0, skipping slew-in-progress; here bit 15 is skipped only while slew_busy_pos is high.
// (RULE3) Digital summary reads high after reset via the reset-seen flag.
// (RULE4) Quiet enable restricts digital OR to flags 15..3.
// (RULE5) Bit 19 ORs analog flags 13..0.
// (RULE6) Bits 16..12 hold the converter channel of the shown result.
// (RULE7) Bits 11..0 hold the 12-bit converter result for that channel.
// (RULE8) Watchdog flag at bit 18, converter busy at bit 17.
// (RULE9) Id word: power die rev 10..8, core rev 7..0, 15..11 zero.
// (RULE10) Oscillator divided by 10,000 gives a 1 kHz tick; the 100 MHz clock here gives 10 kHz.
// (RULE11) Each tick increments a 16-bit counter read in bits 15..0.
// (RULE12) Monitor runs from reset, gated by an enable defaulting on.
// (RULE13) Host polls the count to check and estimate the oscillator.
// (RULE14) Host clears flags by writing one; summaries follow the flags.
// (RULE15) Counter wraps to zero; reading has no side effect.
`timescale 1ns/10ps
`default_nettype none
module dsrb_readback #(
  parameter int DIVIDE = dsrb_pkg::OSC_DIVIDE,
  parameter int CNT_W = 16,
  parameter logic [2:0] POWER_DIE_REV = 3'h1, // Arbitrary value
  parameter logic [7:0] CORE_DIE_REV = 8'h01 // Arbitrary value
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Pins and configuration
  input wire logic i_fault_pin,
  input wire logic i_serial_error_quiet_enable,
  input wire logic i_osc_monitor_enable,
  // Diagnostic sources
  input wire dsrb_pkg::dsrb_diag_t i_diag,
  // Register read port
  input wire dsrb_pkg::dsrb_rd_req_t i_rd,
  output logic o_rd_valid,
  output logic [21:0] o_rd_data,
  output logic o_rd_err,
  // Live summary
  output logic o_digital_diag_summary,
  output logic o_analog_diag_summary
);

  logic tick;
  logic [CNT_W-1:0] tick_cnt_q;
  logic [21:0] status_q;
  logic [21:0] status_d;
  logic dig_or;
  logic ana_or;
  logic [15:0] dig_eff;

  // Builds the common upper bits of each mapped readback word
  function automatic logic [21:0] frame(input logic fault,
                                        input logic [4:0] addr);
    logic [21:0] w;
    w = '0;
    w[dsrb_pkg::FAULT_BIT] = ~fault; // RULE1
    w[dsrb_pkg::ADDR_MSB:dsrb_pkg::ADDR_LSB] = addr;
    return w;
  endfunction

  // ==========================================================================
  // Oscillator monitor
  dsrb_tick_div #(
    .DIVIDE(DIVIDE)
  ) u_div (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_enable(i_osc_monitor_enable), // RULE12
    .o_tick(tick)
  );

  // Wrap is natural modular arithmetic; reads never touch the count
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= tick_cnt_q + CNT_W'(1); // RULE11 RULE15
    end
  end

  // ==========================================================================
  // Summary logic
  always_comb begin
    dig_eff = i_diag.dig_flags;
    // Slew-in-progress at bit 15 drops out only while slew_busy_pos is high
    if (i_diag.slew_busy_pos) begin
      dig_eff[dsrb_pkg::SLEW_BUSY_BIT] = 1'b0; // RULE2
    end
    if (i_serial_error_quiet_enable) begin
      dig_eff[dsrb_pkg::QUIET_LSB-1:0] = '0; // RULE4
    end
    dig_or = |dig_eff; // RULE2 RULE3
    ana_or = |i_diag.ana_flags; // RULE5
  end

  always_comb begin
    status_d = frame(i_fault_pin, dsrb_pkg::OFS_SUMMARY_STATUS);
    status_d[dsrb_pkg::DIG_SUM_BIT] = dig_or; // RULE2
    status_d[dsrb_pkg::ANA_SUM_BIT] = ana_or; // RULE5
    status_d[dsrb_pkg::WDOG_BIT] = i_diag.watchdog; // RULE8
    status_d[dsrb_pkg::CONV_BUSY_BIT] = i_diag.conv_busy; // RULE8
    status_d[dsrb_pkg::CH_MSB:dsrb_pkg::CH_LSB] = i_diag.conv_ch; // RULE6
    status_d[dsrb_pkg::DATA_MSB:0] = i_diag.conv_data; // RULE7
  end

  // Registered so status follows flag clears one cycle later
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_q <= dsrb_pkg::RST_SUMMARY_STATUS; // RULE3
      o_digital_diag_summary <= 1'b1; // RULE3
      o_analog_diag_summary <= 1'b0;
    end else begin
      status_q <= status_d; // RULE14
      o_digital_diag_summary <= dig_or;
      o_analog_diag_summary <= ana_or;
    end
  end

  // ==========================================================================
  // Read port: answer one cycle after the request
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
      o_rd_err <= 1'b0;
    end else begin
      o_rd_valid <= i_rd.valid;
      o_rd_err <= 1'b0;
      if (i_rd.valid) begin
        case (i_rd.addr)
          dsrb_pkg::OFS_SUMMARY_STATUS: begin
            o_rd_data <= status_q;
          end
          dsrb_pkg::OFS_DIE_REVISION: begin
            o_rd_data <= frame(i_fault_pin, dsrb_pkg::OFS_DIE_REVISION);
            o_rd_data[dsrb_pkg::PWR_REV_MSB:dsrb_pkg::PWR_REV_LSB] <=
              POWER_DIE_REV; // RULE9
            o_rd_data[dsrb_pkg::CORE_REV_MSB:0] <= CORE_DIE_REV; // RULE9
          end
          dsrb_pkg::OFS_OSC_TICK_COUNT: begin
            o_rd_data <= frame(i_fault_pin, dsrb_pkg::OFS_OSC_TICK_COUNT);
            o_rd_data[CNT_W-1:0] <= tick_cnt_q; // RULE11 RULE13
          end
          default: begin
            // Unmapped address reads zero and flags the miss
            o_rd_data <= '0;
            o_rd_err <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* hdl/dsrb_tick_div.sv */
// Tick divider: one-cycle enable every DIVIDE cycles while enabled.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module dsrb_tick_div #(
  parameter int DIVIDE = dsrb_pkg::OSC_DIVIDE
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Control
  input wire logic i_enable,
  // Tick
  output logic o_tick
);

  localparam int CW = $clog2(DIVIDE);
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  logic [CW-1:0] cnt_q;

  // ==========================================================================
  // Divide counter
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end else if (!i_enable) begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      o_tick <= 1'b1; // RULE10
    end else begin
      cnt_q <= cnt_q + CW'(1);
      o_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire
